// ---- verilog/serial_port_pkg.sv ----
// shared constants and types of the serial register access port
// assumes one core clock domain; pin levels are resolved by the surrounding pads
package serial_port_pkg;

    // ----------------------------------------------------------------
    // two-wire address and bit counters
    // ----------------------------------------------------------------
    localparam logic [5:0] DEV_ADDR_HI = 6'h34;
    localparam logic [3:0] BIT_LAST = 4'h8;
    localparam logic [3:0] BIT_FIRST = 4'h0;

    // ----------------------------------------------------------------
    // byte position within a two-wire transfer
    // ----------------------------------------------------------------
    localparam logic [1:0] BYTE_ADDR = 2'h0;
    localparam logic [1:0] BYTE_INDEX = 2'h1;
    localparam logic [1:0] BYTE_DATA = 2'h2;

    // ----------------------------------------------------------------
    // four-wire command byte and counters
    // ----------------------------------------------------------------
    localparam int SPI_RW_POS = 7;
    localparam logic [2:0] SPI_BIT_LAST = 3'h7;
    localparam logic [2:0] SPI_BIT_FIRST = 3'h0;

    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] INDEX_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] index;
        logic [7:0] data;
    } reg_write_t;

    typedef enum logic [5:0] {
        TW_IDLE = 6'h01,
        TW_RX = 6'h02,
        TW_ACK = 6'h04,
        TW_STRETCH = 6'h08,
        TW_TX = 6'h10,
        TW_MACK = 6'h20
    } tw_state_t;

endpackage

// ---- verilog/serial_register_access_port.sv ----
// two-wire and four-wire slave port giving a host access to internal registers
// assumes a register file on the core clock that answers o_rd_index combinationally on i_rd_data
// and takes writes from o_wr_word when o_wr_valid and i_wr_ready are both high
`timescale 1ns/1ps

// Notes on behaviour
// R1 - two-wire bytes are eight bits, each followed by one acknowledge slot
// R2 - no limit on data bytes between start and stop
// R3 - acknowledge holds data line low through the whole ninth clock high phase
// R4 - slave holds clock low while it cannot accept a byte; master waits
// R5 - after start comes seven-bit address, direction bit, then slave acknowledge
// R6 - direction bit zero means write, one means read
// R7 - answer only to fixed address whose low bit follows the select pin
// R8 - start is data falling with clock high; always begins new address phase
// R9 - data changes only with clock low; stop is data rising with clock high
// R10 - master ends with stop or issues repeated start for a new phase
// R11 - write: ack address, ack register index, ack and store each data byte
// R12 - each further written byte goes to the next register index
// R13 - read: write the index, repeated start with read bit, slave returns data
// R14 - master ends read with not-acknowledge then stop; slave stops driving
// R15 - each master acknowledge in a read advances index and sends next register
// R16 - master drives active-low select for the whole four-wire transaction
// R17 - serial data output is released while select is high
// R18 - four-wire bytes go most significant bit first
// R19 - four-wire data sampled on clock rise, changed on clock fall
// R20 - master keeps the four-wire clock at or below one megahertz; the host model clocks it at 8 MHz (125 ns period)
// R21 - four-wire access is command byte plus one or more data bytes
// R22 - first command bit selects direction: one read, zero write
// R23 - remaining seven command bits are the register index, top bit first
// R24 - single and burst four-wire reads and writes within one select
// R25 - four-wire burst advances the register index after each data byte
// R26 - host sets two-wire disable early when using the four-wire port
module serial_register_access_port (
    input wire logic i_core_clk,
    input wire logic i_srst,
    input wire logic i_scl,
    output logic o_scl_out,
    output logic o_scl_oe_n,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe_n,
    input wire logic i_cs_n,
    input wire logic i_addr_select_pin,
    output logic o_sdo,
    output logic o_sdo_oe_n,
    input wire logic i_two_wire_port_disable,
    output logic [7:0] o_rd_index,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_valid,
    output serial_port_pkg::reg_write_t o_wr_word,
    input wire logic i_wr_ready
);

    // ----------------------------------------------------------------
    // pin synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [1:0] scl_sync_reg, sda_sync_reg, cs_sync_reg, sel_sync_reg;
    logic scl_prev_reg, sda_prev_reg;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            scl_sync_reg <= 2'h3;
            sda_sync_reg <= 2'h3;
            cs_sync_reg <= 2'h3;
            sel_sync_reg <= 2'h0;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end else begin
            scl_sync_reg <= {scl_sync_reg[0], i_scl};
            sda_sync_reg <= {sda_sync_reg[0], i_sda};
            cs_sync_reg <= {cs_sync_reg[0], i_cs_n};
            sel_sync_reg <= {sel_sync_reg[0], i_addr_select_pin};
            scl_prev_reg <= scl_sync_reg[1];
            sda_prev_reg <= sda_sync_reg[1];
        end
    end

    logic scl_s, sda_s, cs_s, sel_s, scl_rise, scl_fall;
    logic start_seen, stop_seen, tw_on, spi_on;
    assign scl_s = scl_sync_reg[1];
    assign sda_s = sda_sync_reg[1];
    assign cs_s = cs_sync_reg[1];
    assign sel_s = sel_sync_reg[1];
    assign scl_rise = scl_s & ~scl_prev_reg;
    assign scl_fall = ~scl_s & scl_prev_reg;
    assign start_seen = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s; // R8
    assign stop_seen = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s; // R9
    assign tw_on = cs_s & ~i_two_wire_port_disable; // R26
    assign spi_on = ~cs_s; // R16

    // ----------------------------------------------------------------
    // two-entry write buffer
    // ----------------------------------------------------------------
    logic out_valid_reg, spare_valid_reg, buf_full, buf_pop, buf_push, tw_push, spi_push;
    serial_port_pkg::reg_write_t out_word_reg, spare_word_reg, push_word;
    logic [7:0] index_reg, tw_shift_reg, spi_byte;
    assign buf_full = spare_valid_reg;
    assign buf_pop = out_valid_reg & i_wr_ready;
    assign buf_push = tw_push | spi_push;
    assign push_word.index = index_reg;
    assign push_word.data = tw_push ? tw_shift_reg : spi_byte;

    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            out_valid_reg <= 1'b0;
            spare_valid_reg <= 1'b0;
            out_word_reg <= '0;
            spare_word_reg <= '0;
        end else if (buf_pop) begin
            if (spare_valid_reg) begin
                out_word_reg <= spare_word_reg;
                spare_valid_reg <= buf_push;
                spare_word_reg <= push_word;
            end else begin
                out_valid_reg <= buf_push;
                out_word_reg <= push_word;
            end
        end else if (buf_push) begin
            if (!out_valid_reg) begin
                out_valid_reg <= 1'b1;
                out_word_reg <= push_word;
            end else begin
                spare_valid_reg <= 1'b1;
                spare_word_reg <= push_word;
            end
        end
    end

    // ----------------------------------------------------------------
    // two-wire slave engine
    // ----------------------------------------------------------------
    serial_port_pkg::tw_state_t tw_state_reg;
    logic [3:0] tw_cnt_reg;
    logic [1:0] tw_byte_reg;
    logic tw_rw_reg, tw_nack_reg, sda_oe_n_reg, scl_oe_n_reg, tw_byte_done, tw_index_load, tw_inc;
    assign tw_byte_done = (tw_state_reg == serial_port_pkg::TW_RX) && scl_fall &&
                          (tw_cnt_reg == serial_port_pkg::BIT_LAST); // R1
    assign tw_index_load = tw_on && tw_byte_done && (tw_byte_reg == serial_port_pkg::BYTE_INDEX);
    assign tw_push = tw_on && !buf_full &&
                     ((tw_byte_done && tw_byte_reg == serial_port_pkg::BYTE_DATA) ||
                      tw_state_reg == serial_port_pkg::TW_STRETCH); // R11
    assign tw_inc = tw_on && (tw_push ||
                    (tw_state_reg == serial_port_pkg::TW_MACK && scl_rise && !sda_s)); // R15

    always_ff @(posedge i_core_clk) begin
        if (i_srst || !tw_on) begin
            tw_state_reg <= serial_port_pkg::TW_IDLE;
            tw_cnt_reg <= serial_port_pkg::BIT_FIRST;
            tw_byte_reg <= serial_port_pkg::BYTE_ADDR;
            tw_rw_reg <= 1'b0;
            tw_nack_reg <= 1'b1;
            tw_shift_reg <= serial_port_pkg::BYTE_RESET;
            sda_oe_n_reg <= 1'b1;
            scl_oe_n_reg <= 1'b1;
        end else if (start_seen) begin
            tw_state_reg <= serial_port_pkg::TW_RX; // R8
            tw_cnt_reg <= serial_port_pkg::BIT_FIRST;
            tw_byte_reg <= serial_port_pkg::BYTE_ADDR; // R10
            sda_oe_n_reg <= 1'b1;
            scl_oe_n_reg <= 1'b1;
        end else if (stop_seen) begin
            tw_state_reg <= serial_port_pkg::TW_IDLE; // R9
            sda_oe_n_reg <= 1'b1;
            scl_oe_n_reg <= 1'b1;
        end else begin
            case (tw_state_reg)
                serial_port_pkg::TW_RX: begin
                    if (scl_rise) begin
                        tw_shift_reg <= {tw_shift_reg[6:0], sda_s}; // R5
                        tw_cnt_reg <= tw_cnt_reg + 4'h1;
                    end else if (tw_byte_done) begin
                        tw_cnt_reg <= serial_port_pkg::BIT_FIRST;
                        if (tw_byte_reg == serial_port_pkg::BYTE_ADDR) begin
                            if (tw_shift_reg[7:1] == {serial_port_pkg::DEV_ADDR_HI, sel_s}) begin // R7
                                tw_rw_reg <= tw_shift_reg[0]; // R6
                                sda_oe_n_reg <= 1'b0;
                                tw_state_reg <= serial_port_pkg::TW_ACK;
                            end else begin
                                tw_state_reg <= serial_port_pkg::TW_IDLE;
                            end
                        end else if (tw_byte_reg == serial_port_pkg::BYTE_INDEX || !buf_full) begin
                            sda_oe_n_reg <= 1'b0; // R11
                            tw_state_reg <= serial_port_pkg::TW_ACK;
                        end else begin
                            scl_oe_n_reg <= 1'b0; // R4
                            tw_state_reg <= serial_port_pkg::TW_STRETCH;
                        end
                    end
                end
                serial_port_pkg::TW_STRETCH: begin
                    if (!buf_full) begin
                        scl_oe_n_reg <= 1'b1; // R4
                        sda_oe_n_reg <= 1'b0;
                        tw_state_reg <= serial_port_pkg::TW_ACK;
                    end
                end
                serial_port_pkg::TW_ACK: begin
                    if (scl_fall) begin // R3
                        if (tw_byte_reg != serial_port_pkg::BYTE_DATA) begin
                            tw_byte_reg <= tw_byte_reg + 2'h1; // R2
                        end
                        if (tw_rw_reg && tw_byte_reg == serial_port_pkg::BYTE_ADDR) begin
                            tw_state_reg <= serial_port_pkg::TW_TX; // R13
                            tw_shift_reg <= i_rd_data;
                            sda_oe_n_reg <= i_rd_data[7];
                        end else begin
                            tw_state_reg <= serial_port_pkg::TW_RX;
                            sda_oe_n_reg <= 1'b1;
                        end
                    end
                end
                serial_port_pkg::TW_TX: begin
                    if (scl_rise) begin
                        tw_cnt_reg <= tw_cnt_reg + 4'h1;
                    end else if (scl_fall) begin
                        if (tw_cnt_reg == serial_port_pkg::BIT_LAST) begin
                            tw_cnt_reg <= serial_port_pkg::BIT_FIRST;
                            sda_oe_n_reg <= 1'b1;
                            tw_state_reg <= serial_port_pkg::TW_MACK;
                        end else begin
                            sda_oe_n_reg <= tw_shift_reg[6]; // R9
                            tw_shift_reg <= {tw_shift_reg[6:0], 1'b0};
                        end
                    end
                end
                serial_port_pkg::TW_MACK: begin
                    if (scl_rise) begin
                        tw_nack_reg <= sda_s;
                    end else if (scl_fall) begin
                        if (tw_nack_reg) begin
                            tw_state_reg <= serial_port_pkg::TW_IDLE; // R14
                        end else begin
                            tw_state_reg <= serial_port_pkg::TW_TX; // R15
                            tw_shift_reg <= i_rd_data;
                            sda_oe_n_reg <= i_rd_data[7];
                        end
                    end
                end
                default: begin
                    tw_state_reg <= serial_port_pkg::TW_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // four-wire slave engine
    // ----------------------------------------------------------------
    logic [2:0] spi_cnt_reg;
    logic [7:0] spi_shift_reg, spi_tx_reg;
    logic spi_first_reg, spi_rw_reg, sdo_reg, sdo_oe_n_reg, spi_done, spi_index_load, spi_inc;
    assign spi_byte = {spi_shift_reg[6:0], sda_s}; // R18
    assign spi_done = spi_on && scl_rise && (spi_cnt_reg == serial_port_pkg::SPI_BIT_LAST); // R19
    assign spi_index_load = spi_done && spi_first_reg; // R23
    assign spi_push = spi_done && !spi_first_reg && !spi_rw_reg && !buf_full; // R24
    assign spi_inc = spi_done && !spi_first_reg; // R25

    always_ff @(posedge i_core_clk) begin
        if (i_srst || !spi_on) begin
            spi_cnt_reg <= serial_port_pkg::SPI_BIT_FIRST;
            spi_shift_reg <= serial_port_pkg::BYTE_RESET;
            spi_tx_reg <= serial_port_pkg::BYTE_RESET;
            spi_first_reg <= 1'b1;
            spi_rw_reg <= 1'b0;
            sdo_reg <= 1'b0;
            sdo_oe_n_reg <= 1'b1; // R17
        end else begin
            if (scl_rise) begin
                spi_shift_reg <= spi_byte; // R19
                spi_cnt_reg <= spi_cnt_reg + 3'h1;
                if (spi_done && spi_first_reg) begin
                    spi_first_reg <= 1'b0; // R21
                    spi_rw_reg <= spi_byte[serial_port_pkg::SPI_RW_POS]; // R22
                end
            end else if (scl_fall && spi_rw_reg && !spi_first_reg) begin
                sdo_oe_n_reg <= 1'b0;
                if (spi_cnt_reg == serial_port_pkg::SPI_BIT_FIRST) begin
                    sdo_reg <= i_rd_data[7]; // R18
                    spi_tx_reg <= {i_rd_data[6:0], 1'b0};
                end else begin
                    sdo_reg <= spi_tx_reg[7]; // R19
                    spi_tx_reg <= {spi_tx_reg[6:0], 1'b0};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // register index
    // ----------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_srst) begin
            index_reg <= serial_port_pkg::INDEX_RESET;
        end else if (tw_index_load) begin
            index_reg <= tw_shift_reg; // R11
        end else if (spi_index_load) begin
            index_reg <= {1'b0, spi_byte[6:0]}; // R23
        end else if (tw_inc || spi_inc) begin
            index_reg <= index_reg + 8'h01; // R12
        end
    end

    // ----------------------------------------------------------------
    // pin drivers and outputs
    // ----------------------------------------------------------------
    logic pin_low_reg;
    always_ff @(posedge i_core_clk) begin
        pin_low_reg <= 1'b0;
    end
    assign o_scl_out = pin_low_reg;
    assign o_sda_out = pin_low_reg;
    assign o_scl_oe_n = scl_oe_n_reg;
    assign o_sda_oe_n = sda_oe_n_reg;
    assign o_sdo = sdo_reg;
    assign o_sdo_oe_n = sdo_oe_n_reg;
    assign o_rd_index = index_reg;
    assign o_wr_valid = out_valid_reg;
    assign o_wr_word = out_word_reg;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_sdo_released: assert property ( // R17
        @(posedge i_core_clk) disable iff (i_srst) cs_s |=> o_sdo_oe_n
    ) else $error("serial output driven while deselected");
    a_stretch_release: assert property ( // R4
        @(posedge i_core_clk) disable iff (i_srst)
        (tw_state_reg == serial_port_pkg::TW_STRETCH && !buf_full && tw_on) |=> (o_scl_oe_n && !o_sda_oe_n)
    ) else $error("clock not released when buffer had room");
    a_addr_match: assert property ( // R7
        @(posedge i_core_clk) disable iff (i_srst)
        (tw_on && tw_byte_done && tw_byte_reg == serial_port_pkg::BYTE_ADDR) |=>
        ((tw_state_reg == serial_port_pkg::TW_ACK) ==
         ($past(tw_shift_reg[7:1]) == {serial_port_pkg::DEV_ADDR_HI, $past(sel_s)}))
    ) else $error("address acknowledge does not follow match");
    a_start_new: assert property ( // R8
        @(posedge i_core_clk) disable iff (i_srst)
        (start_seen && tw_on) |=> (tw_state_reg == serial_port_pkg::TW_RX && tw_cnt_reg == 4'h0 &&
                                   tw_byte_reg == serial_port_pkg::BYTE_ADDR)
    ) else $error("start did not open an address phase");
    a_stop_idle: assert property ( // R9
        @(posedge i_core_clk) disable iff (i_srst)
        (stop_seen && tw_on) |=> (tw_state_reg == serial_port_pkg::TW_IDLE && o_sda_oe_n && o_scl_oe_n)
    ) else $error("stop did not free the bus");
    a_ack_held_low: assert property ( // R3
        @(posedge i_core_clk) disable iff (i_srst)
        (tw_state_reg == serial_port_pkg::TW_ACK) |-> !o_sda_oe_n
    ) else $error("acknowledge slot not held low");
    a_nack_ends: assert property ( // R14
        @(posedge i_core_clk) disable iff (i_srst)
        (tw_on && tw_state_reg == serial_port_pkg::TW_MACK && scl_fall && tw_nack_reg) |=>
        (tw_state_reg == serial_port_pkg::TW_IDLE && o_sda_oe_n)
    ) else $error("slave kept driving after not-acknowledge");
    a_tw_write_inc: assert property ( // R12
        @(posedge i_core_clk) disable iff (i_srst)
        tw_push |=> (index_reg == $past(index_reg) + 8'h01 && o_wr_valid)
    ) else $error("two-wire write did not advance index");
    a_spi_burst_inc: assert property ( // R25
        @(posedge i_core_clk) disable iff (i_srst)
        spi_inc |=> index_reg == $past(index_reg) + 8'h01
    ) else $error("four-wire burst did not advance index");

endmodule // serial_register_access_port

// ---- verification/host_master_model.sv ----
// host master model: drives the shared clock, data and select pins
// assumes the bench resolves each pin from all parties' enables
`timescale 1ns/1ps
module host_master_model (
    output logic o_scl,
    output logic o_sda,
    output logic o_cs_n,
    input wire logic i_scl,
    input wire logic i_sda,
    input wire logic i_sdo,
    output logic o_stretched,
    output logic o_stuck
);
    // ----------------------------------------------------------------
    // pin sequences
    // ----------------------------------------------------------------
    localparam realtime Q = 31.25;
    initial begin
        o_scl = 1'b1;
        o_sda = 1'b1;
        o_cs_n = 1'b1;
        o_stretched = 1'b0;
        o_stuck = 1'b0;
    end
    task automatic tw_bit(input logic b, output logic r);
        int n = 0;
        o_sda = b;
        #Q;
        o_scl = 1'b1;
        #Q;
        while (i_scl !== 1'b1 && n < 4000 && !o_stuck) begin
            #5;
            n++;
        end
        if (n > 0) o_stretched = 1'b1;
        if (n == 4000) o_stuck = 1'b1;
        r = i_sda;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    task automatic tw_start();
        o_sda = 1'b1;
        #Q;
        o_scl = 1'b1;
        #Q;
        o_sda = 1'b0;
        #Q;
        o_scl = 1'b0;
        #Q;
    endtask
    task automatic tw_stop();
        o_sda = 1'b0;
        #Q;
        o_scl = 1'b1;
        #Q;
        o_sda = 1'b1;
        #Q;
    endtask
    task automatic tw_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) tw_bit(tx[i], rx[i]);
        tw_bit(mack, ack);
    endtask
    task automatic spi_select(input logic on);
        o_scl = 1'b0;
        #(2 * Q);
        o_cs_n = !on;
        o_sda = 1'b1;
        #(2 * Q);
        o_scl = !on;
    endtask
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_sda = tx[i];
            #(2 * Q);
            o_scl = 1'b1;
            rx[i] = i_sdo;
            #(2 * Q);
            o_scl = 1'b0;
        end
    endtask
endmodule // host_master_model

// ---- verification/tb.sv ----
// testbench of the serial register access port with a host model and a register file
// assumes the design package is compiled first
`timescale 1ns/1ps
module tb;
    // ----------------------------------------------------------------
    // environment
    // ----------------------------------------------------------------
    logic i_core_clk = 1'b0;
    logic i_srst = 1'b1;
    logic addr_sel = 1'b0;
    logic disable_tw = 1'b0;
    logic wr_ready = 1'b1;
    logic [7:0] regs [256];
    logic [7:0] rx;
    logic ack;
    int err_total = 0;
    int n_checks = 0;
    wire scl_m, sda_m, cs_n, stretched, stuck;
    wire scl_oe_n, scl_out, sda_oe_n, sda_out, sdo, sdo_oe_n, wr_valid;
    wire [7:0] rd_index;
    serial_port_pkg::reg_write_t wr_word;
    wire scl_w = scl_m & (scl_oe_n | scl_out);
    wire sda_w = sda_m & (sda_oe_n | sda_out);
    wire sdo_w = sdo_oe_n ? addr_sel : sdo;
    wire [7:0] rd_data = regs[rd_index];
    always #2.5 i_core_clk = ~i_core_clk;
    always @(posedge i_core_clk) begin
        if (wr_valid && wr_ready) regs[wr_word.index] <= wr_word.data;
    end
    serial_register_access_port serial_register_access_port_i (
        .i_core_clk(i_core_clk), .i_srst(i_srst), .i_scl(scl_w), .o_scl_out(scl_out),
        .o_scl_oe_n(scl_oe_n), .i_sda(sda_w), .o_sda_out(sda_out), .o_sda_oe_n(sda_oe_n),
        .i_cs_n(cs_n), .i_addr_select_pin(addr_sel), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n),
        .i_two_wire_port_disable(disable_tw), .o_rd_index(rd_index), .i_rd_data(rd_data),
        .o_wr_valid(wr_valid), .o_wr_word(wr_word), .i_wr_ready(wr_ready));
    host_master_model host_master_model_i (.o_scl(scl_m), .o_sda(sda_m), .o_cs_n(cs_n), .i_scl(scl_w),
        .i_sda(sda_w), .i_sdo(sdo_w), .o_stretched(stretched), .o_stuck(stuck));
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tw_send(input logic [7:0] b, input logic exp_ack);
        host_master_model_i.tw_byte(b, 1'b1, rx, ack);
        check(ack, exp_ack);
    endtask
    task automatic sc_tw_burst_write();
        @(negedge i_core_clk);
        wr_ready = 1'b0;
        fork
            begin
                host_master_model_i.tw_start();
                tw_send(8'hd0, 1'b0);
                tw_send(8'h10, 1'b0);
                tw_send(8'ha5, 1'b0);
                tw_send(8'h3c, 1'b0);
                tw_send(8'h96, 1'b0);
                host_master_model_i.tw_stop();
            end
            begin
                repeat (1500) @(negedge i_core_clk);
                wr_ready = 1'b1;
            end
        join
        check(stretched, 1'b1);
        check(regs[8'h10], 8'ha5);
        check(regs[8'h11], 8'h3c);
        check(regs[8'h12], 8'h96);
    endtask
    task automatic sc_tw_read();
        host_master_model_i.tw_start();
        tw_send(8'hd0, 1'b0);
        tw_send(8'h10, 1'b0);
        host_master_model_i.tw_start();
        tw_send(8'hd1, 1'b0);
        host_master_model_i.tw_byte(8'hff, 1'b0, rx, ack);
        check(rx, 8'ha5);
        host_master_model_i.tw_byte(8'hff, 1'b1, rx, ack);
        check(rx, 8'h3c);
        check(sda_oe_n, 1'b1);
        check(rd_index, 8'h11);
        host_master_model_i.tw_stop();
    endtask
    task automatic sc_tw_address();
        addr_sel = 1'b1;
        repeat (10) @(negedge i_core_clk);
        host_master_model_i.tw_start();
        tw_send(8'hd0, 1'b1);
        host_master_model_i.tw_start();
        tw_send(8'hd2, 1'b0);
        tw_send(8'h20, 1'b0);
        tw_send(8'h77, 1'b0);
        host_master_model_i.tw_stop();
        check(regs[8'h20], 8'h77);
        addr_sel = 1'b0;
    endtask
    task automatic sc_spi();
        @(negedge i_core_clk);
        disable_tw = 1'b1;
        host_master_model_i.spi_select(1'b1);
        host_master_model_i.spi_byte(8'h30, rx);
        host_master_model_i.spi_byte(8'h11, rx);
        host_master_model_i.spi_byte(8'h22, rx);
        host_master_model_i.spi_select(1'b0);
        check(regs[8'h30], 8'h11);
        check(regs[8'h31], 8'h22);
        host_master_model_i.spi_select(1'b1);
        host_master_model_i.spi_byte(8'hb0, rx);
        host_master_model_i.spi_byte(8'h00, rx);
        check(rx, 8'h11);
        check(sdo_oe_n, 1'b0);
        host_master_model_i.spi_byte(8'h00, rx);
        check(rx, 8'h22);
        host_master_model_i.spi_select(1'b0);
        repeat (10) @(negedge i_core_clk);
        check(sdo_oe_n, 1'b1);
        disable_tw = 1'b0;
    endtask
    initial begin
        foreach (regs[k]) regs[k] = 8'h00;
        repeat (10) @(negedge i_core_clk);
        i_srst = 1'b0;
        check({sda_oe_n, scl_oe_n, sdo_oe_n, wr_valid}, 8'h0e);
        check(rd_index, 8'h00);
        repeat (5) @(negedge i_core_clk);
        sc_tw_burst_write();
        sc_tw_read();
        sc_tw_address();
        sc_spi();
        check(stuck, 1'b0);
        wrap_up();
    end
endmodule // tb
